// File: rtl/edac_status_regs.svh
// Notes on behaviour
// [RULE1] read data phase, pio and check on: odd parity checked at strobe trailing edge
// [RULE2] parity fault latches in bytes 0 and 2 bit 5 until block end; no side effect
// [RULE3] read: per interleave fault flag, 0-7 in byte 1, 8-9 in byte 2 bits 0-1
// [RULE4] interleave flags set in ecc field, cleared at end of next data field
// [RULE5] read: crc flag byte 2 bit 6 set on non-zero residue, cleared likewise
// [RULE6] read-only syndrome queue twenty bytes deep toward the host
// [RULE7] dma setting still allows pio reads; pio setting ignores dma grants
// [RULE8] queue occupancy shown on request pin and byte 0 request bit
// [RULE9] per read block: four crc residue bytes if enabled, syndromes, two status copies
// [RULE10] one residue or syndrome byte every eight clocks pushed into queue
// [RULE11] syndrome count is 16, 8 or 4 per interleave times interleave factor
// [RULE12] write mode: no syndromes, but two status bytes at every block end
// [RULE13] request asserted at every block end regardless of threshold
// [RULE14] queue emptied at end of every data field
// [RULE15] host holds each read strobe longer than two clocks, at most clock/5 rate
// [RULE16] dma is demand burst: request high while any byte remains queued
// [RULE17] dma master never reads while request is low
// [RULE18] host drains bytes at least as fast as they are made
// [RULE19] read overflow latches flag bit 3 in bytes 0 and 2; byte count kept
// [RULE20] status reads never clear flags; only field or block boundaries do
`ifndef EDAC_STATUS_REGS_SVH
`define EDAC_STATUS_REGS_SVH

// processor bus addresses
`define ADDR_GENERAL_STATUS 8'h0b
`define ADDR_ILV_LOW_STATUS 8'h0c
`define ADDR_ILV_HIGH_STATUS 8'h0d
`define ADDR_SYNDROME_QUEUE 8'h0e

// field positions
`define BIT_BUSY 0
`define BIT_REQUEST 1
`define BIT_ECC_ERR 2
`define BIT_OVERFLOW 3
`define BIT_PARITY 5
`define BIT_CRC 6

// reset values
`define FLAGS_RESET 10'h000
`define PIN_SYNC_RESET 22'h1bffff
`define ADDR_RESET 8'h00

// timing and counts
`define BYTE_PERIOD 3'd7
`define CRC_BYTES 8'd4
`define FILL_BYTE 8'hff
`define QUEUE_DEPTH 20

`endif

// File: rtl/edac_status_pkg.sv
package edac_status_pkg;
   // syndrome generation sequence
   typedef enum logic [2:0] {
      GS_IDLE,
      GS_GEN,
      GS_WAIT_END,
      GS_STAT1,
      GS_STAT2
   } gen_state_e;
   // polynomial degree selection
   typedef enum logic [1:0] {
      DEG_4,
      DEG_8,
      DEG_16
   } degree_e;
endpackage

// File: rtl/syndrome_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module syndrome_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 20
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // ************************************************************
   // storage and pointers
   // ************************************************************
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   generate
      if (DEPTH < 2) begin : g_bad
         $error("syndrome_fifo depth must be at least 2");
      end
   endgenerate

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_ready && out_valid;

   // memory write; no reset needed on data
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and occupancy; flush discards everything
   always_ff @(posedge sys_clk) begin
      if (reset || flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= nxt(wr_q);
         end
         if (pop) begin
            rd_q <= nxt(rd_q);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // syndrome_fifo
`default_nettype wire

// File: rtl/edac_syndrome_status_report.sv
`timescale 1ns/10ps
`default_nettype none
`include "edac_status_regs.svh"
module edac_syndrome_status_report
   import edac_status_pkg::*;
#(
   parameter int FIFO_DEPTH = `QUEUE_DEPTH
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic read_mode,
   input wire logic crc_option,
   input wire logic dma_mode,
   input wire logic parity_check_disable,
   input wire logic grant_active_high,
   input wire logic [1:0] poly_degree,
   input wire logic [3:0] interleave_factor,
   input wire logic data_field,
   input wire logic data_field_end,
   input wire logic block_end,
   input wire logic [7:0] check_byte,
   input wire logic ale,
   input wire logic cs_n,
   input wire logic rd_strobe_n,
   input wire logic [7:0] ad_in,
   input wire logic syndrome_grant,
   input wire logic controller_bus_strobe_n,
   input wire logic [7:0] controller_bus_bits,
   input wire logic controller_bus_parity,
   output logic [7:0] ad_out,
   output logic ad_oe_n,
   output logic syndrome_request
);

   generate
      if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255) begin : g_bad_depth
         $error("syndrome queue depth out of range");
      end
   endgenerate

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [21:0] pin_meta_q;
   logic [21:0] pin_sync_q;
   logic ale_s, cs_n_s, rd_n_s, grant_s, cbs_n_s, cbp_s;
   logic [7:0] cbb_s;
   logic [7:0] adi_s;

   // every pin passes two flops before any logic sees it
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         // grant resets to its idle level so no false trailing edge follows
         pin_meta_q <= `PIN_SYNC_RESET | {3'b000, !grant_active_high, 18'h00000};
         pin_sync_q <= `PIN_SYNC_RESET | {3'b000, !grant_active_high, 18'h00000};
      end else begin
         pin_meta_q <= {ale, cs_n, rd_strobe_n, syndrome_grant, controller_bus_strobe_n,
                        controller_bus_parity, controller_bus_bits, ad_in};
         pin_sync_q <= pin_meta_q;
      end
   end
   assign {ale_s, cs_n_s, rd_n_s, grant_s, cbs_n_s, cbp_s, cbb_s, adi_s} = pin_sync_q;

   // ************************************************************
   // strobe tracking and address latch
   // ************************************************************
   logic pio_act, grant_act, cbs_act;
   logic pio_act_q, grant_act_q, cbs_act_q;
   logic pio_end, grant_end, cb_end;
   logic [7:0] addr_q;

   assign pio_act = !cs_n_s && !rd_n_s;
   // grants only count in dma mode, pio reads always do
   assign grant_act = dma_mode && (grant_s == grant_active_high); // see [RULE7]
   assign cbs_act = !cbs_n_s;
   assign pio_end = pio_act_q && !pio_act;
   // a grant cut by leaving dma mode must not pop
   assign grant_end = dma_mode && grant_act_q && !grant_act; // see [RULE7]
   assign cb_end = cbs_act_q && !cbs_act;

   // previous strobe levels for trailing-edge detection
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pio_act_q <= 1'b0;
         grant_act_q <= 1'b0;
         cbs_act_q <= 1'b0;
      end else begin
         pio_act_q <= pio_act;
         grant_act_q <= grant_act;
         cbs_act_q <= cbs_act;
      end
   end

   // address follows the bus while the latch enable is high
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         addr_q <= `ADDR_RESET;
      end else if (ale_s) begin
         addr_q <= adi_s;
      end
   end

   // ************************************************************
   // controller bus parity check
   // ************************************************************
   logic par_check, par_bad, bus_parity_fault_q;

   assign par_check = read_mode && data_field && !dma_mode && !parity_check_disable;
   // nine bits must hold an odd count of ones
   assign par_bad = cb_end && par_check && !(^{cbb_s, cbp_s}); // see [RULE1]

   // latched until block end; set beats a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bus_parity_fault_q <= 1'b0;
      end else if (par_bad) begin
         bus_parity_fault_q <= 1'b1; // see [RULE2]
      end else if (block_end) begin
         bus_parity_fault_q <= 1'b0; // see [RULE2]
      end
   end

   // ************************************************************
   // syndrome generation sequence
   // ************************************************************
   gen_state_e state_q;
   logic [2:0] pace_q;
   logic [7:0] idx_q;
   logic [7:0] total_q;
   logic [3:0] ilv_q;
   logic byte_take, in_crc;

   function automatic logic [7:0] block_bytes(input logic [1:0] deg, input logic [3:0] fac,
                                               input logic crc);
      logic [7:0] per;
      per = (deg == DEG_16) ? 8'd16 : (deg == DEG_8) ? 8'd8 : 8'd4;
      return 8'(per * {4'h0, fac}) + (crc ? `CRC_BYTES : 8'h00); // see [RULE11]
   endfunction

   assign byte_take = (state_q == GS_GEN) && (pace_q == `BYTE_PERIOD); // see [RULE10]
   assign in_crc = crc_option && (idx_q < `CRC_BYTES); // see [RULE9]

   // residue first, then syndromes, then two status copies at block end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= GS_IDLE;
         pace_q <= 3'h0;
         idx_q <= 8'h00;
         total_q <= 8'h00;
         ilv_q <= 4'h0;
      end else begin
         case (state_q)
            GS_IDLE: begin
               if (data_field_end && read_mode) begin
                  state_q <= GS_GEN; // see [RULE9]
                  pace_q <= 3'h0;
                  idx_q <= 8'h00;
                  ilv_q <= 4'h0;
                  total_q <= block_bytes(poly_degree, interleave_factor, crc_option);
               end else if (block_end) begin
                  state_q <= GS_STAT1; // see [RULE12]
               end
            end
            GS_GEN: begin
               pace_q <= pace_q + 3'h1;
               if (byte_take) begin
                  idx_q <= idx_q + 8'h01;
                  if (!in_crc) begin
                     ilv_q <= (ilv_q == interleave_factor - 4'h1) ? 4'h0 : ilv_q + 4'h1;
                  end
                  if (idx_q == total_q - 8'h01) begin
                     state_q <= GS_WAIT_END;
                  end
               end
            end
            GS_WAIT_END: begin
               if (block_end) begin
                  state_q <= GS_STAT1;
               end
            end
            GS_STAT1: begin
               state_q <= GS_STAT2;
            end
            GS_STAT2: begin
               state_q <= GS_IDLE;
            end
            default: begin
               state_q <= GS_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // error flags
   // ************************************************************
   logic [9:0] ilv_err_q;
   logic crc_err_q, sfo_q, eerr;
   logic real_push, fill_push, q_in_ready;

   assign eerr = |ilv_err_q;

   // one flag per interleave, cleared at data field end unless set that cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ilv_err_q <= `FLAGS_RESET;
      end else begin
         for (int k = 0; k < 10; k++) begin
            if (byte_take && !in_crc && read_mode && check_byte != 8'h00
                && ilv_q == 4'(k)) begin
               ilv_err_q[k] <= 1'b1; // see [RULE3]
            end else if (data_field_end) begin
               ilv_err_q[k] <= 1'b0; // see [RULE4]
            end
         end
      end
   end

   // crc residue and overflow flags share the data field clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         crc_err_q <= 1'b0;
         sfo_q <= 1'b0;
      end else begin
         if (byte_take && in_crc && check_byte != 8'h00) begin
            crc_err_q <= 1'b1; // see [RULE5]
         end else if (data_field_end) begin
            crc_err_q <= 1'b0; // see [RULE5]
         end
         if (real_push && !q_in_ready && read_mode) begin
            sfo_q <= 1'b1; // see [RULE19]
         end else if (data_field_end) begin
            sfo_q <= 1'b0; // see [RULE19]
         end
      end
   end

   // ************************************************************
   // status bytes
   // ************************************************************
   logic q_out_valid;
   logic [7:0] q_out_data;
   logic [7:0] status0, status1, status2;

   // reads are side-effect free; nothing here clears on access
   assign status0 = {2'b00, bus_parity_fault_q, 1'b0, sfo_q, eerr, q_out_valid, // see [RULE20]
                     state_q != GS_IDLE};
   assign status1 = ilv_err_q[7:0];
   assign status2 = {1'b0, crc_err_q, bus_parity_fault_q, 1'b0, sfo_q, eerr, ilv_err_q[9:8]};

   function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] s0,
                                            input logic [7:0] s1, input logic [7:0] s2,
                                            input logic [7:0] q);
      case (a)
         `ADDR_GENERAL_STATUS: return s0;
         `ADDR_ILV_LOW_STATUS: return s1;
         `ADDR_ILV_HIGH_STATUS: return s2;
         `ADDR_SYNDROME_QUEUE: return q;
         default: return 8'h00;
      endcase
   endfunction

   // ************************************************************
   // syndrome queue feed
   // ************************************************************
   logic [7:0] owed_q;
   logic [7:0] push_data;
   logic pop;

   // bytes lost to a full queue are owed and replaced by filler later,
   // so the host still sees the right count; the filler is garbage
   assign real_push = byte_take || state_q == GS_STAT1 || state_q == GS_STAT2;
   assign fill_push = !real_push && owed_q != 8'h00;
   assign push_data = byte_take ? check_byte :
                      (state_q == GS_STAT1) ? status1 : // see [RULE9]
                      (state_q == GS_STAT2) ? status2 : `FILL_BYTE;

   always_ff @(posedge sys_clk) begin
      if (reset || data_field_end) begin
         owed_q <= 8'h00;
      end else if (real_push && !q_in_ready) begin
         owed_q <= owed_q + 8'h01; // see [RULE19]
      end else if (fill_push && q_in_ready) begin
         owed_q <= owed_q - 8'h01;
      end
   end

   // a pop on the trailing edge of the read; empty reads are ignored
   assign pop = (pio_end && addr_q == `ADDR_SYNDROME_QUEUE) || grant_end; // see [RULE7]

   syndrome_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_queue (
      .sys_clk(sys_clk),
      .reset(reset),
      .flush(data_field_end), // see [RULE14]
      .in_valid(real_push || fill_push),
      .in_ready(q_in_ready),
      .in_data(push_data),
      .out_valid(q_out_valid), // see [RULE6]
      .out_ready(pop),
      .out_data(q_out_data)
   );

   // ************************************************************
   // processor bus outputs
   // ************************************************************
   // request follows occupancy, so it is high after every block end too
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         syndrome_request <= 1'b0;
      end else begin
         syndrome_request <= q_out_valid; // see [RULE8] [RULE13] [RULE16]
      end
   end

   // bus driven only while a read or grant is active
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ad_out <= 8'h00;
         ad_oe_n <= 1'b1;
      end else begin
         ad_oe_n <= !(pio_act || grant_act);
         ad_out <= grant_act ? q_out_data
                             : reg_read(addr_q, status0, status1, status2, q_out_data);
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_parity_latch;
      par_bad |=> bus_parity_fault_q ##1 (bus_parity_fault_q || $past(block_end));
   endproperty
   a_parity_latch: assert property (p_parity_latch) else $error("parity fault not latched"); // see [RULE2]

   property p_parity_check;
      cb_end && par_check && (^{cbb_s, cbp_s}) && !bus_parity_fault_q && !block_end |=> !bus_parity_fault_q;
   endproperty
   a_parity_check: assert property (p_parity_check) else $error("good parity flagged"); // see [RULE1]

   property p_byte_pace;
      byte_take |=> !byte_take [*7];
   endproperty
   a_byte_pace: assert property (p_byte_pace) else $error("byte pacing not eight"); // see [RULE10]

   property p_crc_flag;
      byte_take && in_crc && check_byte != 8'h00 |=> crc_err_q;
   endproperty
   a_crc_flag: assert property (p_crc_flag) else $error("crc flag missed"); // see [RULE5]

   property p_flag_clear;
      data_field_end && !byte_take |=> ilv_err_q == 10'h000 && !crc_err_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared"); // see [RULE4]

   property p_flush;
      data_field_end |=> !q_out_valid ##1 !syndrome_request;
   endproperty
   a_flush: assert property (p_flush) else $error("queue not emptied"); // see [RULE14]

   property p_write_status;
      block_end && !read_mode && state_q == GS_IDLE && !data_field_end
         |-> ##[1:3] (state_q == GS_STAT2);
   endproperty
   a_write_status: assert property (p_write_status) else $error("no status bytes"); // see [RULE12]

   property p_request;
      real_push && q_in_ready |-> ##2 (syndrome_request || $past(data_field_end, 2));
   endproperty
   a_request: assert property (p_request) else $error("request not raised"); // see [RULE8]

   property p_no_pio_dma;
      !dma_mode && !pio_end |-> !pop;
   endproperty
   a_no_pio_dma: assert property (p_no_pio_dma) else $error("grant served in pio"); // see [RULE7]

   property p_overflow;
      real_push && !q_in_ready && read_mode && !data_field_end |=> sfo_q && owed_q != 8'h00;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not tracked"); // see [RULE19]

endmodule // edac_syndrome_status_report
`default_nettype wire

// File: sim/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// host side: processor reading by pio, or dma master
// ************************************************************
module host_model (
   input wire logic sys_clk,
   input wire logic syndrome_request,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe_n,
   output logic ale,
   output logic cs_n,
   output logic rd_strobe_n,
   output logic [7:0] ad_in,
   output logic syndrome_grant
);
   logic [7:0] host_val = 8'h00;

   // shared bus level: the device wins while it drives
   assign ad_in = ad_oe_n ? host_val : ad_out;

   // all pins inactive until the first access
   initial begin
      ale = 1'b0;
      cs_n = 1'b1;
      rd_strobe_n = 1'b1;
      syndrome_grant = 1'b0;
   end

   // strobe held four clocks, well past the two-clock minimum
   task automatic pio_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      ale <= 1'b1;
      host_val <= addr;
      repeat (2) @(posedge sys_clk);
      ale <= 1'b0;
      @(posedge sys_clk);
      host_val <= ~addr;  // released bus must not keep a stale value
      cs_n <= 1'b0;
      rd_strobe_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      data = ad_oe_n ? 8'hxx : ad_out;  // undriven bus reads as unknown
      cs_n <= 1'b1;
      rd_strobe_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask

   // caller only enters while the request stands, gap lets it settle
   task automatic dma_read(output logic [7:0] data);
      @(posedge sys_clk);
      syndrome_grant <= 1'b1;
      repeat (4) @(posedge sys_clk);
      data = ad_oe_n ? 8'hxx : ad_out;
      syndrome_grant <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule // host_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "edac_status_regs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("FAIL %0t got %h expected %h", $time, got, exp); end end
module tb
   import edac_status_pkg::*;
;
   // ************************************************************
   // stimulus signals and design
   // ************************************************************
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic read_mode = 1'b0, crc_option = 1'b0, dma_mode = 1'b0, parity_check_disable = 1'b0;
   logic [1:0] poly_degree = 2'h0;
   logic [3:0] interleave_factor = 4'h1;
   logic data_field = 1'b0, data_field_end = 1'b0, block_end = 1'b0;
   logic [7:0] check_byte = 8'h00, controller_bus_bits = 8'h00, d;
   logic controller_bus_strobe_n = 1'b1, controller_bus_parity = 1'b0;
   logic ale, cs_n, rd_strobe_n, syndrome_grant, ad_oe_n, syndrome_request;
   logic [7:0] ad_in, ad_out;
   int mismatches = 0, tests_run = 0, cycles = 0, n;

   // 8 ns period
   always #4 sys_clk = ~sys_clk;

   edac_syndrome_status_report i_dut (.sys_clk(sys_clk), .reset(reset),
      .read_mode(read_mode), .crc_option(crc_option), .dma_mode(dma_mode),
      .parity_check_disable(parity_check_disable), .grant_active_high(1'b1),
      .poly_degree(poly_degree), .interleave_factor(interleave_factor),
      .data_field(data_field), .data_field_end(data_field_end), .block_end(block_end),
      .check_byte(check_byte), .ale(ale), .cs_n(cs_n), .rd_strobe_n(rd_strobe_n),
      .ad_in(ad_in), .syndrome_grant(syndrome_grant),
      .controller_bus_strobe_n(controller_bus_strobe_n),
      .controller_bus_bits(controller_bus_bits),
      .controller_bus_parity(controller_bus_parity), .ad_out(ad_out),
      .ad_oe_n(ad_oe_n), .syndrome_request(syndrome_request));

   host_model i_host (.sys_clk(sys_clk), .syndrome_request(syndrome_request),
      .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ale(ale), .cs_n(cs_n),
      .rd_strobe_n(rd_strobe_n), .ad_in(ad_in), .syndrome_grant(syndrome_grant));

   // ************************************************************
   // helpers
   // ************************************************************
   // residue bytes nonzero; syndromes nonzero only for masked interleaves
   function automatic logic [7:0] byte_val(input int i, input bit crc, input int fac,
                                           input logic [9:0] mask);
      int s;
      s = crc ? i - 4 : i;
      if (s < 0) begin
         return 8'h10 + 8'(i);
      end
      return mask[s % fac] ? (8'h80 | 8'(s)) : 8'h00;
   endfunction

   task automatic pulse_dfe();
      @(posedge sys_clk);
      data_field_end <= 1'b1;
      data_field <= 1'b0;
      @(posedge sys_clk);
      data_field_end <= 1'b0;
   endtask

   task automatic pulse_be();
      @(posedge sys_clk);
      block_end <= 1'b1;
      @(posedge sys_clk);
      block_end <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   // byte changes mid-pace so the sampling cycle has margin both ways
   task automatic feed(input int cnt, input bit crc, input int fac, input logic [9:0] mask);
      for (int i = 0; i < cnt; i++) begin
         repeat (4) @(posedge sys_clk);
         check_byte <= byte_val(i, crc, fac, mask);
         repeat (4) @(posedge sys_clk);
      end
   endtask

   task automatic cbus(input logic [7:0] b, input logic p);
      @(posedge sys_clk);
      controller_bus_bits <= b;
      controller_bus_parity <= p;
      controller_bus_strobe_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      controller_bus_strobe_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      controller_bus_bits <= ~b;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      `CHK(syndrome_request, 1'b0)
      `CHK(ad_oe_n, 1'b1)
      i_host.pio_read(8'h05, d);
      `CHK(d, 8'h00)
      i_host.pio_read(`ADDR_ILV_HIGH_STATUS, d);
      `CHK(d, 8'h00)
      $display("test reset done");
   endtask

   task automatic t_read_block();
      read_mode <= 1'b1;
      crc_option <= 1'b1;
      poly_degree <= 2'(DEG_4);
      interleave_factor <= 4'h2;
      data_field <= 1'b1;
      pulse_dfe();
      feed(12, 1'b1, 2, 10'h002);
      pulse_be();
      `CHK(syndrome_request, 1'b1)
      i_host.pio_read(`ADDR_ILV_HIGH_STATUS, d);
      `CHK(d, 8'h44)
      i_host.pio_read(`ADDR_ILV_LOW_STATUS, d);
      `CHK(d, 8'h02)
      i_host.pio_read(`ADDR_GENERAL_STATUS, d);
      `CHK(d & 8'h2e, 8'h06)
      i_host.pio_read(`ADDR_ILV_HIGH_STATUS, d);
      `CHK(d, 8'h44)
      for (int i = 0; i < 14; i++) begin
         i_host.pio_read(`ADDR_SYNDROME_QUEUE, d);
         `CHK(d, i < 12 ? byte_val(i, 1'b1, 2, 10'h002) : (i == 12 ? 8'h02 : 8'h44))
      end
      `CHK(syndrome_request, 1'b0)
      $display("test read block done");
   endtask

   task automatic t_write_dma();
      read_mode <= 1'b0;
      pulse_be();
      `CHK(syndrome_request, 1'b1)
      i_host.dma_read(d);
      `CHK(syndrome_request, 1'b1)
      i_host.pio_read(`ADDR_SYNDROME_QUEUE, d);
      `CHK(d, 8'h02)
      dma_mode <= 1'b1;
      n = 0;
      while (syndrome_request === 1'b1 && n < 8) begin
         i_host.dma_read(d);
         n++;
      end
      `CHK(d, 8'h44)
      `CHK(n, 1)
      dma_mode <= 1'b0;
      pulse_be();
      pulse_be();
      pulse_dfe();
      repeat (3) @(posedge sys_clk);
      `CHK(syndrome_request, 1'b0)
      i_host.pio_read(`ADDR_ILV_HIGH_STATUS, d);
      `CHK(d, 8'h00)
      `CHK(ad_oe_n, 1'b1)
      $display("test write dma done");
   endtask

   task automatic t_parity();
      read_mode <= 1'b1;
      data_field <= 1'b1;
      cbus(8'h01, 1'b0);
      i_host.pio_read(`ADDR_GENERAL_STATUS, d);
      `CHK(d & 8'h20, 8'h00)
      cbus(8'h03, 1'b0);
      i_host.pio_read(`ADDR_ILV_HIGH_STATUS, d);
      `CHK(d & 8'h20, 8'h20)
      read_mode <= 1'b0;
      pulse_be();
      i_host.pio_read(`ADDR_GENERAL_STATUS, d);
      `CHK(d & 8'h20, 8'h00)
      read_mode <= 1'b1;
      parity_check_disable <= 1'b1;
      cbus(8'h03, 1'b0);
      i_host.pio_read(`ADDR_GENERAL_STATUS, d);
      `CHK(d & 8'h20, 8'h00)
      parity_check_disable <= 1'b0;
      read_mode <= 1'b0;
      pulse_dfe();
      $display("test parity done");
   endtask

   // degree 16 over ten interleaves: 160 syndromes into a 20-byte queue
   task automatic t_overflow();
      read_mode <= 1'b1;
      crc_option <= 1'b0;
      poly_degree <= 2'(DEG_16);
      interleave_factor <= 4'ha;
      pulse_dfe();
      feed(160, 1'b0, 10, 10'h300);
      pulse_be();
      i_host.pio_read(`ADDR_ILV_HIGH_STATUS, d);
      `CHK(d, 8'h0f)
      i_host.pio_read(`ADDR_GENERAL_STATUS, d);
      `CHK(d & 8'h2c, 8'h0c)
      n = 0;
      while (syndrome_request === 1'b1 && n < 200) begin
         i_host.pio_read(`ADDR_SYNDROME_QUEUE, d);
         n++;
      end
      `CHK(n, 162)
      $display("test overflow done");
   endtask

   // ************************************************************
   // run control
   // ************************************************************
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // hang guard, far beyond the few thousand cycles needed
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (3) @(posedge sys_clk);
      t_reset();
      t_read_block();
      t_write_dma();
      t_parity();
      t_overflow();
      summarize();
   end
endmodule // tb
`default_nettype wire
